// file: logic/bbs_core.sv
// Execution of not-zero branch, relative branch and file bit set
//
// What this block does
// - Taken not-zero branch targets PC+2+2n, two cycles
// - Not-zero branch: one word, 1 or 2 cycles
// - Zero set: PC advances two, no write
// - Relative branch offset -1024..1023, PC+2+2n
// - Relative branch encoding 1101 0 plus offset
// - Relative branch always two cycles
// - Bit set encoding 1000 bbba ffffffff
// - Access bit 0 access bank, 1 bank select
// - Not-zero branch encoding 1110 0001 nnnnnnnn
// - Not-zero branch taken only when zero flag clear; relative branch always taken
`timescale 1ns/10ps
`include "bbs_params.svh"
module bbs_core
    import bbs_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Fetch pipeline
    input wire logic [15:0] instr,
    input wire logic instr_valid,
    input wire logic zero_flag,
    input wire logic [3:0] bank_select_register,
    // Data memory read data
    input wire logic [7:0] mem_rdata,
    // Program counter and pipeline control
    output logic [20:0] pc,
    output logic flush,
    output logic [3:0] phase,
    // Data memory access
    output logic [11:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [7:0] mem_wdata
);
    logic rst_m;
    logic rst_s;
    bbs_phase_t q;
    bbs_phase_t next_q;
    logic nop_cycle;
    logic [15:0] ir;
    logic is_brzc;
    logic is_always;
    logic is_sfb;
    logic take;
    logic [20:0] offset2;
    logic [7:0] mod_data;
    logic [2:0] bit_sel;
    logic sfb_live;
    logic [7:0] set_mask;

    // Reset release
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_m <= 1'b0;
            rst_s <= 1'b0;
        end
        else
        begin
            rst_m <= 1'b1;
            rst_s <= rst_m;
        end
    end

    bbs_decode u_dec (
        .instr(ir),
        .zero_flag(zero_flag),
        .is_brzc(is_brzc),
        .is_always(is_always),
        .is_sfb(is_sfb),
        .take(take),
        .offset2(offset2)
    );

    always_comb
    begin
        case (q)
            BBS_Q1: next_q = BBS_Q2;
            BBS_Q2: next_q = BBS_Q3;
            BBS_Q3: next_q = BBS_Q4;
            BBS_Q4: next_q = BBS_Q1;
            default: next_q = BBS_Q1;
        endcase
    end

    // Four phase sequencer
    always_ff @(posedge clock or negedge rst_s)
    begin
        if (!rst_s)
        begin
            q <= BBS_Q1;
            phase <= `BBS_PH_Q1;
        end
        else
        begin
            q <= next_q;
            phase <= next_q;
        end
    end

    // Instruction latch leaving Q4; the word behind a taken branch is dropped
    always_ff @(posedge clock or negedge rst_s)
    begin
        if (!rst_s)
        begin
            ir <= 16'h0000;
        end
        else if (q == BBS_Q4)
        begin
            if (!instr_valid || (take && !nop_cycle))
            begin
                ir <= 16'h0000;
            end
            else
            begin
                ir <= instr;
            end
        end
    end

    // Program counter, written in Q4; flags are never touched
    always_ff @(posedge clock or negedge rst_s)
    begin
        if (!rst_s)
        begin
            pc <= `BBS_PC_RESET;
        end
        else if (q == BBS_Q4)
        begin
            if (!nop_cycle && take)
            begin
                pc <= pc + offset2;
            end
            else
            begin
                pc <= pc + `BBS_PC_STEP;
            end
        end
    end

    // No-op cycle and flush level after a taken branch
    always_ff @(posedge clock or negedge rst_s)
    begin
        if (!rst_s)
        begin
            nop_cycle <= 1'b0;
            flush <= 1'b0;
        end
        else if (q == BBS_Q4)
        begin
            nop_cycle <= !nop_cycle && take;
            flush <= !nop_cycle && take;
        end
    end

    assign bit_sel = ir[11:9];
    assign sfb_live = is_sfb && !nop_cycle;

    // One-hot mask of the bit to be set
    generate
        for (genvar gi = 0; gi < 8; gi++)
        begin : g_mask
            assign set_mask[gi] = (bit_sel == 3'(gi));
        end
    endgenerate

    // Read strobe and banked address, standing through Q2
    always_ff @(posedge clock or negedge rst_s)
    begin
        if (!rst_s)
        begin
            mem_rd <= 1'b0;
            mem_addr <= 12'h000;
        end
        else
        begin
            mem_rd <= sfb_live && (next_q == BBS_Q2);
            if (sfb_live && (next_q == BBS_Q2))
            begin
                if (ir[8])
                begin
                    mem_addr <= {bank_select_register, ir[7:0]};
                end
                else
                begin
                    mem_addr <= {`BBS_ACCESS_BANK, ir[7:0]};
                end
            end
        end
    end

    // Modify at the end of Q2, read data settled by then
    always_ff @(posedge clock or negedge rst_s)
    begin
        if (!rst_s)
        begin
            mod_data <= 8'h00;
        end
        else if (sfb_live && (next_q == BBS_Q3))
        begin
            mod_data <= mem_rdata | set_mask;
        end
    end

    // Write strobe and data, standing through Q4
    always_ff @(posedge clock or negedge rst_s)
    begin
        if (!rst_s)
        begin
            mem_wr <= 1'b0;
            mem_wdata <= 8'h00;
        end
        else
        begin
            mem_wr <= sfb_live && (next_q == BBS_Q4);
            if (sfb_live && (next_q == BBS_Q4))
            begin
                mem_wdata <= mod_data;
            end
        end
    end
endmodule

// file: logic/bbs_params.svh
// Constants for the branch and bit-set execution block
`ifndef BBS_PARAMS_SVH
`define BBS_PARAMS_SVH
`define BBS_OP_BRZC_HI 8'hE1
`define BBS_OP_ALWAYS_HI 5'h1A
`define BBS_OP_SFB_HI 4'h8
`define BBS_PC_RESET 21'h00_0000
`define BBS_PC_STEP 21'h00_0002
`define BBS_ACCESS_BANK 4'h0
`define BBS_PH_Q1 4'h1
`define BBS_PH_Q2 4'h2
`define BBS_PH_Q3 4'h4
`define BBS_PH_Q4 4'h8
`endif

// file: logic/bbs_pkg.sv
// Types for the branch and bit-set execution block
package bbs_pkg;
    typedef enum logic [3:0] {
        BBS_Q1 = 4'b0001,
        BBS_Q2 = 4'b0010,
        BBS_Q3 = 4'b0100,
        BBS_Q4 = 4'b1000
    } bbs_phase_t;
    typedef enum logic [2:0] {
        BBS_OP_NONE = 3'b001,
        BBS_OP_BRANCH = 3'b010,
        BBS_OP_SETBIT = 3'b100
    } bbs_op_t;
endpackage

// file: logic/bbs_decode.sv
// Instruction decoder for the three supported instructions
`timescale 1ns/10ps
`include "bbs_params.svh"
module bbs_decode
    import bbs_pkg::*;
(
    // Instruction word and flag
    input wire logic [15:0] instr,
    input wire logic zero_flag,
    // Decode results
    output logic is_brzc,
    output logic is_always,
    output logic is_sfb,
    output logic take,
    output logic [20:0] offset2
);
    always_comb
    begin
        is_brzc = (instr[15:8] == `BBS_OP_BRZC_HI);
        is_always = (instr[15:11] == `BBS_OP_ALWAYS_HI);
        is_sfb = (instr[15:12] == `BBS_OP_SFB_HI);
        take = is_always | (is_brzc & ~zero_flag);
        if (is_always)
        begin
            offset2 = {{9{instr[10]}}, instr[10:0], 1'b0};
        end
        else
        begin
            offset2 = {{12{instr[7]}}, instr[7:0], 1'b0};
        end
    end
endmodule

// file: tb/bbs_checker.sv
// Port assertions for the branch and bit-set block
`timescale 1ns/10ps
module bbs_checker (
    // Clock, reset and inputs
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [15:0] instr,
    input wire logic instr_valid,
    input wire logic zero_flag,
    input wire logic [3:0] bank_select_register,
    input wire logic [7:0] mem_rdata,
    // Outputs
    input wire logic [20:0] pc,
    input wire logic flush,
    input wire logic [3:0] phase,
    input wire logic [11:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata
);
    logic [1:0] age;
    logic [15:0] ir;
    logic irv;
    wire live = &age;
    wire q4 = live && phase == 4'h8;
    wire run = irv && !flush;
    wire jmp = run && ir[15:11] == 5'h1a;
    wire brz = run && ir[15:8] == 8'he1;
    wire sfb = run && ir[15:12] == 4'h8;
    wire [20:0] far = 21'(signed'({ir[10:0], 1'b0}));
    wire [20:0] near = 21'(signed'({ir[7:0], 1'b0}));
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    // Settle time after reset release
    always_ff @(posedge clock or negedge rst_b)
        if (!rst_b)
            age <= 2'h0;
        else if (!live)
            age <= age + 2'h1;
    // Word executing in the current cycle
    always_ff @(posedge clock or negedge rst_b)
        if (!rst_b)
            {ir, irv} <= 17'h0_0000;
        else if (phase == 4'h8)
            {ir, irv} <= {instr, instr_valid};
    phase_walk_a: assert property (live && phase != 4'h8 |=> phase == $past(phase) << 1)
        else $error("phase order");
    jump_target_a: assert property (q4 && jmp
        |=> flush && pc == $past(pc) + $past(far)) else $error("branch target");
    nz_taken_a: assert property (q4 && brz && !zero_flag
        |=> flush && pc == $past(pc) + $past(near)) else $error("taken target");
    pc_step_a: assert property (q4 && !jmp && !(brz && !zero_flag)
        |=> !flush && pc == $past(pc) + 21'h2) else $error("pc step");
    read_slot_a: assert property (live |-> mem_rd == (phase == 4'h2 && sfb))
        else $error("read slot");
    write_slot_a: assert property (live |-> mem_wr == (q4 && sfb))
        else $error("write slot");
    bank_addr_a: assert property (mem_rd
        |-> mem_addr == {ir[8] ? bank_select_register : 4'h0, ir[7:0]}) else $error("bank");
    set_bit_a: assert property (mem_wr |-> mem_wdata == (mem_rdata | (8'h01 << ir[11:9])))
        else $error("bit set");
    cover property (q4 && jmp);
    cover property (q4 && brz && zero_flag);
    cover property (mem_wr);
    cover property (mem_rd && ir[8]);
endmodule
bind bbs_core bbs_checker chk (.*);

// file: tb/testbench.sv
// Random bench for the branch and bit-set block
`timescale 1ns/10ps
module testbench;
    logic clock = 1'h0, rst_b = 1'h0, instr_valid = 1'h0, zero_flag = 1'h0, ev = 1'h0, ef = 1'h0;
    logic flush, mem_rd, mem_wr;
    logic [15:0] instr = 16'h0, ex = 16'h0;
    logic [7:0] mem_rdata = 8'h0, mem_wdata;
    logic [3:0] bank_select_register = 4'h5, phase;
    logic [11:0] mem_addr;
    logic [20:0] pc, last;
    logic [21:0] want;
    logic [20:0] want_w = 21'h0, got_w = 21'h0;
    logic [31:0] r = 32'h050a_f257;
    int n_fail = 0, num_checks = 0, t;
    always #2.5 clock = !clock;
    bbs_core dut (.*);
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    // Taken flag and pc step of one executed word
    function automatic logic [21:0] step(logic [15:0] x, logic v, f, z);
        if (!v || f || !(x[15:11] == 5'h1a || (x[15:8] == 8'he1 && !z)))
            return 22'h2;
        return {1'b1, x[12] ? 21'(signed'({x[10:0], 1'b0})) : 21'(signed'({x[7:0], 1'b0}))};
    endfunction
    // Expected bit-set write {strobe, address, data} of one executed word
    function automatic logic [20:0] wr_exp(logic [15:0] x, logic v, f, logic [3:0] bank,
        logic [7:0] rd);
        if (!v || f || x[15:12] != 4'h8)
            return 21'h0;
        return {1'b1, x[8] ? bank : 4'h0, x[7:0], rd | (8'h01 << x[11:9])};
    endfunction
    task automatic chk_wr(logic [20:0] got, exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %0t bit set write %h, want %h", $time, got, exp);
        end
    endtask
    task automatic chk(logic [21:0] got, exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %0t flush and pc step %h, want %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        if (n_fail == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge clock);
        #1 rst_b = 1'h1;
        repeat (4) @(posedge clock);
        for (int i = 0; i < 600; i++)
        begin
            t = 0;
            do
            begin
                @(posedge clock);
                #1 t++;
                if (mem_wr !== 1'b0)
                    got_w = {mem_wr, mem_addr, mem_wdata};
            end while (phase !== 4'h1 && t < 9);
            if (t > 8)
            begin
                n_fail++;
                $display("mismatch %0t phase sequence stuck", $time);
                report_and_stop();
            end
            if (i > 1)
            begin
                chk({flush, pc - last}, want);
                chk_wr(got_w, want_w);
            end
            got_w = 21'h0;
            last = pc;
            r = xs(r);
            zero_flag = r[16];
            bank_select_register = {r[23:21], r[17]};
            want = step(ex, ev, ef, r[16]);
            want_w = wr_exp(ex, ev, ef, {r[23:21], r[17]}, r[31:24]);
            ef = want[21];
            ev = |r[20:18];
            instr_valid = ev;
            mem_rdata = r[31:24];
            // Offset extremes first, then random words
            case (i < 4 ? 2'h1 : (i < 8 ? 2'h0 : r[13:12]))
                2'h0: ex = {8'he1, i < 8 ? {i[1], {7{!i[1]}}} : r[7:0]};
                2'h1: ex = {5'h1a, i < 4 ? {i[1], {10{!i[1]}}} : r[10:0]};
                2'h2: ex = {4'h8, r[11:0]};
                default: ex = r[31:16];
            endcase
            instr = ex;
        end
        report_and_stop();
    end
endmodule
